// [design/cbc_regs.sv]
// configuration and identification byte bank of a two-pair clock buffer
`timescale 1ns/100ps
`include "cbc_consts.svh"
module cbc_regs #(
  parameter logic [1:0] IMP_DEFAULT = `CBC_IMP_100,
  parameter logic [3:0] REV_CODE = 4'h3, // value arbitrary
  parameter logic [3:0] MAKER_CODE = 4'h5, // value arbitrary
  parameter logic [1:0] PART_TYPE = 2'h2, // value arbitrary
  parameter logic [5:0] PART_ID = 6'h15 // value arbitrary
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic idx_wr,
  input wire logic [4:0] idx_data,
  input wire logic byte_wr,
  input wire logic [7:0] wdata,
  input wire logic rd_start,
  input wire logic rd_ack,
  input wire logic rd_stop,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic sleep_pin,
  input wire logic [1:0] pair_enable_pin,
  input wire logic [1:0] pin_rate_code,
  input wire logic [1:0] pair_oe_ctrl,
  output logic [1:0] output_rate_code,
  output logic feedback_edge_rate,
  output logic keep_config_in_sleep,
  output logic [4:0] readback_length,
  output logic [1:0] feedback_output_impedance,
  output logic [1:0] pair0_impedance,
  output logic [1:0] clock_pair_output_run,
  output logic [1:0] clock_pair_output_true,
  output logic [1:0] clock_pair_output_comp
);
  logic rst_m_r, rst_sync_b;
  logic [4:0] pin_s;
  logic sleep_s;
  logic [1:0] oe_pin_s, rate_pin_s;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_sync_b <= rst_m_r;
    end
  end

  cbc_sync3 #(.WIDTH(5)) u_pins (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .async_in({sleep_pin, pair_enable_pin, pin_rate_code}),
    .sync_out(pin_s)
  );
  assign sleep_s = pin_s[4];
  assign oe_pin_s = pin_s[3:2];
  assign rate_pin_s = pin_s[1:0];

  // configuration state
  logic rate_en_r, rate_en_nxt, edge_r, edge_nxt, keep_r, keep_nxt;
  logic [1:0] rate_r, rate_nxt, part_r, part_nxt, fbimp_r, fbimp_nxt;
  logic [1:0] p0imp_r, p0imp_nxt, stop_r, stop_nxt;
  logic [5:0] id_r, id_nxt;
  logic [4:0] len_r, len_nxt, ptr_r, ptr_nxt;

  function automatic logic [7:0] rd_byte(input logic [4:0] idx);
    begin
      case (idx)
        `CBC_IDX_RATE: rd_byte = `CBC_RATE_RSV_BITS | {2'h0, rate_en_r, rate_r, 2'h0, edge_r};
        `CBC_IDX_IDENT: rd_byte = {REV_CODE, MAKER_CODE};
        `CBC_IDX_PART: rd_byte = {part_r, id_r};
        `CBC_IDX_LEN: rd_byte = {3'h0, len_r};
        `CBC_IDX_SLEEP: rd_byte = {1'b0, keep_r, 6'h00};
        `CBC_IDX_STOPFB: rd_byte = {fbimp_r, 4'h0, stop_r};
        `CBC_IDX_PAIR0: rd_byte = {p0imp_r, 6'h00};
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  logic rd_busy;
  logic wr_go;
  assign wr_go = byte_wr && !rd_busy;

  always_comb begin
    rate_en_nxt = rate_en_r;
    rate_nxt = rate_r;
    edge_nxt = edge_r;
    part_nxt = part_r;
    id_nxt = id_r;
    len_nxt = len_r;
    keep_nxt = keep_r;
    fbimp_nxt = fbimp_r;
    stop_nxt = stop_r;
    p0imp_nxt = p0imp_r;
    // only named fields take a write; reserved bits and byte 5 are dropped
    if (wr_go) begin
      case (ptr_r)
        `CBC_IDX_RATE: begin
          rate_en_nxt = wdata[`CBC_B_RATE_EN];
          rate_nxt = wdata[`CBC_B_RATE_HI:`CBC_B_RATE_LO];
          edge_nxt = wdata[`CBC_B_FB_EDGE];
        end
        `CBC_IDX_PART: begin
          part_nxt = wdata[`CBC_B_PART_HI:`CBC_B_PART_LO];
          id_nxt = wdata[`CBC_B_ID_HI:0];
        end
        `CBC_IDX_LEN: len_nxt = wdata[`CBC_B_LEN_HI:0];
        `CBC_IDX_SLEEP: keep_nxt = wdata[`CBC_B_KEEP];
        `CBC_IDX_STOPFB: begin
          fbimp_nxt = wdata[`CBC_B_IMP_HI:`CBC_B_IMP_LO];
          stop_nxt = wdata[`CBC_B_STOP_HI:`CBC_B_STOP_LO];
        end
        `CBC_IDX_PAIR0: p0imp_nxt = wdata[`CBC_B_IMP_HI:`CBC_B_IMP_LO];
        default: ;
      endcase
    end
    // sleep without retention wins over any write in the same cycle
    if (sleep_s && !keep_r) begin
      rate_en_nxt = `CBC_RST_RATE_EN;
      rate_nxt = `CBC_RST_RATE;
      edge_nxt = `CBC_RST_FB_EDGE;
      part_nxt = PART_TYPE;
      id_nxt = PART_ID;
      len_nxt = `CBC_RST_LEN;
      keep_nxt = `CBC_RST_KEEP;
      fbimp_nxt = IMP_DEFAULT;
      stop_nxt = `CBC_RST_STOP;
      p0imp_nxt = IMP_DEFAULT;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rate_en_r <= `CBC_RST_RATE_EN;
      rate_r <= `CBC_RST_RATE;
      edge_r <= `CBC_RST_FB_EDGE;
      part_r <= PART_TYPE;
      id_r <= PART_ID;
      len_r <= `CBC_RST_LEN;
      keep_r <= `CBC_RST_KEEP;
      fbimp_r <= IMP_DEFAULT;
      stop_r <= `CBC_RST_STOP;
      p0imp_r <= IMP_DEFAULT;
    end else begin
      rate_en_r <= rate_en_nxt;
      rate_r <= rate_nxt;
      edge_r <= edge_nxt;
      part_r <= part_nxt;
      id_r <= id_nxt;
      len_r <= len_nxt;
      keep_r <= keep_nxt;
      fbimp_r <= fbimp_nxt;
      stop_r <= stop_nxt;
      p0imp_r <= p0imp_nxt;
    end
  end

  // block read sequencer and index pointer
  cbc_pkg::cbc_rd_state_t st_r, st_nxt;
  logic [4:0] left_r, left_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  assign rd_busy = (st_r == cbc_pkg::CBC_SEND);

  always_comb begin
    st_nxt = st_r;
    ptr_nxt = ptr_r;
    left_nxt = left_r;
    rdat_nxt = rdat_r;
    case (st_r)
      cbc_pkg::CBC_IDLE: begin
        if (idx_wr) begin
          ptr_nxt = idx_data;
        end else if (rd_start) begin
          st_nxt = cbc_pkg::CBC_SEND;
          rdat_nxt = {3'h0, len_r};
          left_nxt = len_r;
        end else if (byte_wr) begin
          ptr_nxt = ptr_r + 5'h01;
        end
      end
      cbc_pkg::CBC_SEND: begin
        if (rd_stop || (rd_ack && left_r == 5'h00)) begin
          st_nxt = cbc_pkg::CBC_IDLE;
          rdat_nxt = 8'h00;
        end else if (rd_ack) begin
          rdat_nxt = rd_byte(ptr_r);
          ptr_nxt = ptr_r + 5'h01;
          left_nxt = left_r - 5'h01;
        end
      end
      default: st_nxt = cbc_pkg::CBC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= cbc_pkg::CBC_IDLE;
      ptr_r <= 5'h00;
      left_r <= 5'h00;
      rdat_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      ptr_r <= ptr_nxt;
      left_r <= left_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // applied rate and pair control
  logic [1:0] eff_rate_r, eff_rate_nxt, run_r, run_nxt, tru_r, tru_nxt;

  always_comb begin
    eff_rate_nxt = rate_pin_s;
    // reserved code leaves the running rate alone
    if (rate_en_r) begin
      eff_rate_nxt = (rate_r == `CBC_RATE_RSV) ? eff_rate_r : rate_r;
    end
    run_nxt = pair_oe_ctrl & oe_pin_s;
    tru_nxt = {2{stop_r[1]}};
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      eff_rate_r <= `CBC_RST_RATE;
      run_r <= 2'h0;
      tru_r <= 2'h0;
    end else begin
      eff_rate_r <= eff_rate_nxt;
      run_r <= run_nxt;
      tru_r <= tru_nxt;
    end
  end

  assign rd_valid = rd_busy;
  assign rd_data = rdat_r;
  assign output_rate_code = eff_rate_r;
  assign feedback_edge_rate = edge_r;
  assign keep_config_in_sleep = keep_r;
  assign readback_length = len_r;
  assign feedback_output_impedance = fbimp_r;
  assign pair0_impedance = p0imp_r;
  assign clock_pair_output_run = run_r;
  assign clock_pair_output_true = tru_r;
  assign clock_pair_output_comp = 2'h0;

  // byte that an ack fetches, as a plain signal for the step check
  logic [7:0] ack_byte;
  assign ack_byte = rd_byte(ptr_r);

  sequence s_read_open;
    rd_start && !rd_busy && !idx_wr;
  endsequence
  sequence s_first_byte;
    rd_valid && rd_data == {3'h0, $past(len_r)};
  endsequence
  sequence s_ack_step;
    rd_busy && rd_ack && !rd_stop && left_r != 5'h00;
  endsequence

  chk_rate_gated: assert property (!rate_en_r |=> eff_rate_r == $past(rate_pin_s))
    else $error("rate not taken from pins while software rate disabled");
  chk_rate_soft: assert property (rate_en_r && rate_r != `CBC_RATE_RSV
    |=> eff_rate_r == $past(rate_r))
    else $error("software rate code not applied");
  chk_ident_fixed: assert property (s_ack_step ##0 (ptr_r == `CBC_IDX_IDENT)
    |=> rd_data == {REV_CODE, MAKER_CODE})
    else $error("identity byte changed");
  chk_rsv_zero: assert property (s_ack_step ##0 (ptr_r == `CBC_IDX_RSV4
    || ptr_r == `CBC_IDX_RSV8 || ptr_r == `CBC_IDX_RSV9) |=> rd_data == 8'h00)
    else $error("reserved byte reads non-zero");
  chk_count_first: assert property (s_read_open |=> s_first_byte)
    else $error("block read did not open with byte count");
  chk_read_step: assert property (s_ack_step
    |=> rd_data == $past(ack_byte) && ptr_r == $past(ptr_r) + 5'h01)
    else $error("block read byte out of sequence");
  chk_len_write: assert property (wr_go && ptr_r == `CBC_IDX_LEN && !(sleep_s && !keep_r)
    |=> len_r == $past(wdata[`CBC_B_LEN_HI:0]))
    else $error("length write lost");
  chk_sleep_clear: assert property (sleep_s && !keep_r |=> edge_r == `CBC_RST_FB_EDGE
    && len_r == `CBC_RST_LEN && keep_r && stop_r == `CBC_RST_STOP && p0imp_r == IMP_DEFAULT)
    else $error("sleep did not restore defaults");
  chk_pair_halt: assert property (!pair_oe_ctrl[0] |=> !clock_pair_output_run[0])
    else $error("pair 0 runs with control bit clear");
endmodule

// [design/cbc_consts.svh]
// byte indices, field positions and reset values of the clock buffer config bank
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH
`define CBC_IDX_RATE 5'h03
`define CBC_IDX_RSV4 5'h04
`define CBC_IDX_IDENT 5'h05
`define CBC_IDX_PART 5'h06
`define CBC_IDX_LEN 5'h07
`define CBC_IDX_RSV8 5'h08
`define CBC_IDX_RSV9 5'h09
`define CBC_IDX_SLEEP 5'h0A
`define CBC_IDX_STOPFB 5'h0B
`define CBC_IDX_PAIR0 5'h0C
`define CBC_B_RATE_EN 5
`define CBC_B_RATE_HI 4
`define CBC_B_RATE_LO 3
`define CBC_B_FB_EDGE 0
`define CBC_B_KEEP 6
`define CBC_B_IMP_HI 7
`define CBC_B_IMP_LO 6
`define CBC_B_STOP_HI 1
`define CBC_B_STOP_LO 0
`define CBC_B_LEN_HI 4
`define CBC_B_PART_HI 7
`define CBC_B_PART_LO 6
`define CBC_B_ID_HI 5
`define CBC_RATE_RSV 2'h3
`define CBC_RST_RATE_EN 1'h0
`define CBC_RST_RATE 2'h0
`define CBC_RST_FB_EDGE 1'h1
`define CBC_RST_LEN 5'h08
`define CBC_RST_KEEP 1'h1
`define CBC_RST_STOP 2'h0
`define CBC_RATE_RSV_BITS 8'h84
`define CBC_IMP_100 2'h2
`endif

// [design/cbc_pkg.sv]
// shared types of the clock buffer config bank
package cbc_pkg;
  typedef enum logic [1:0] {
    CBC_IDLE = 2'h0,
    CBC_SEND = 2'h1
  } cbc_rd_state_t;
endpackage

// [design/cbc_sync3.sv]
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module cbc_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  always_comb begin
    // per bit: only a settled level is passed on
    out_nxt = (s2_r & s3_r) | (out_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule

// [tb/cbc_host.sv]
// host-side model issuing index writes, byte writes and block reads
`timescale 1ns/100ps
module cbc_host (
  input wire logic clk,
  output logic idx_wr,
  output logic [4:0] idx_data,
  output logic byte_wr,
  output logic [7:0] wdata,
  output logic rd_start,
  output logic rd_ack,
  output logic rd_stop,
  input wire logic [7:0] rd_data
);
  logic [7:0] got [0:31];
  initial begin
    {idx_wr, byte_wr, rd_start, rd_ack, rd_stop} = 5'h00;
    idx_data = 5'h00;
    wdata = 8'h00;
  end
  // released lines show the inverse so a stale value never passes
  task automatic set_idx(input logic [4:0] i);
    @(negedge clk);
    idx_wr = 1'b1;
    idx_data = i;
    @(negedge clk);
    idx_wr = 1'b0;
    idx_data = ~i;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    set_idx(i);
    byte_wr = 1'b1;
    wdata = d;
    @(negedge clk);
    byte_wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] i, input int n);
    set_idx(i);
    rd_start = 1'b1;
    @(negedge clk);
    rd_start = 1'b0;
    got[0] = rd_data;
    // ack stays high across bytes, one byte per edge
    rd_ack = 1'b1;
    for (int k = 1; k <= n; k++) begin
      @(negedge clk);
      got[k] = rd_data;
    end
    rd_ack = 1'b0;
    rd_stop = 1'b1;
    @(negedge clk);
    rd_stop = 1'b0;
  endtask
endmodule

// [tb/clock_buffer_config_regs_tb_top.sv]
// self-checking bench of the clock buffer config bank
`timescale 1ns/100ps
`include "cbc_consts.svh"
module clock_buffer_config_regs_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sleep_pin = 1'b0;
  logic [1:0] pair_enable_pin = 2'h3;
  logic [1:0] pin_rate_code = 2'h1;
  logic [1:0] pair_oe_ctrl = 2'h3;
  logic idx_wr, byte_wr, rd_start, rd_ack, rd_stop, rd_valid;
  logic feedback_edge_rate, keep_config_in_sleep;
  logic [7:0] rd_data, wdata;
  logic [4:0] idx_data, readback_length;
  logic [1:0] output_rate_code, feedback_output_impedance, pair0_impedance;
  logic [1:0] clock_pair_output_run, clock_pair_output_true, clock_pair_output_comp;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  // identity values arbitrary; 85-ohm variant picked to leave the default
  cbc_regs #(.IMP_DEFAULT(2'h1), .REV_CODE(4'hA), .MAKER_CODE(4'h6), .PART_TYPE(2'h1),
    .PART_ID(6'h2C)) i_cbc_regs (.clk, .rst_b, .idx_wr, .idx_data, .byte_wr, .wdata,
    .rd_start, .rd_ack, .rd_stop, .rd_valid, .rd_data, .sleep_pin, .pair_enable_pin,
    .pin_rate_code, .pair_oe_ctrl, .output_rate_code, .feedback_edge_rate,
    .keep_config_in_sleep, .readback_length, .feedback_output_impedance, .pair0_impedance,
    .clock_pair_output_run, .clock_pair_output_true, .clock_pair_output_comp);
  cbc_host i_cbc_host (.clk, .idx_wr, .idx_data, .byte_wr, .wdata, .rd_start, .rd_ack,
    .rd_stop, .rd_data);
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic t_reset;
    logic [7:0] ev [0:7] = '{8'h85, 8'h00, 8'hA6, 8'h6C, 8'h08, 8'h00, 8'h00, 8'h40};
    chk(output_rate_code, 2'h1);
    chk(feedback_edge_rate, 1'b1);
    chk(keep_config_in_sleep, 1'b1);
    chk({feedback_output_impedance, pair0_impedance}, 4'h5);
    chk(clock_pair_output_run, 2'h3);
    i_cbc_host.rd(`CBC_IDX_RATE, 8);
    chk(i_cbc_host.got[0], 8'h08);
    for (int k = 0; k < 8; k++) begin
      chk(i_cbc_host.got[k+1], ev[k]);
    end
    i_cbc_host.rd(`CBC_IDX_STOPFB, 2);
    chk(i_cbc_host.got[1], 8'h40);
    chk(i_cbc_host.got[2], 8'h40);
  endtask
  task automatic t_rate;
    logic [7:0] wv [0:5] = '{8'h11, 8'h31, 8'h29, 8'h21, 8'h39, 8'h10};
    logic [1:0] ev [0:5] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
    for (int k = 0; k < 6; k++) begin
      i_cbc_host.wr(`CBC_IDX_RATE, wv[k]);
      // applied rate lags the field by one register
      @(negedge clk);
      chk(output_rate_code, ev[k]);
    end
    chk(feedback_edge_rate, 1'b0);
    i_cbc_host.rd(`CBC_IDX_RATE, 1);
    chk(i_cbc_host.got[1], 8'h94);
  endtask
  task automatic t_ident;
    i_cbc_host.wr(`CBC_IDX_IDENT, 8'hFF);
    i_cbc_host.wr(`CBC_IDX_PART, 8'h9B);
    i_cbc_host.wr(`CBC_IDX_RSV4, 8'hFF);
    i_cbc_host.wr(`CBC_IDX_RSV8, 8'hFF);
    i_cbc_host.rd(`CBC_IDX_RSV4, 5);
    chk(i_cbc_host.got[1], 8'h00);
    chk(i_cbc_host.got[2], 8'hA6);
    chk(i_cbc_host.got[3], 8'h9B);
    chk(i_cbc_host.got[5], 8'h00);
  endtask
  task automatic t_len;
    i_cbc_host.wr(`CBC_IDX_LEN, 8'hE3);
    chk(readback_length, 5'h03);
    // one ack past the count must close rather than show byte 10
    i_cbc_host.rd(`CBC_IDX_LEN, 4);
    chk(i_cbc_host.got[0], 8'h03);
    chk(i_cbc_host.got[1], 8'h03);
    chk(i_cbc_host.got[4], 8'h00);
    chk(rd_valid, 1'b0);
  endtask
  task automatic t_stop;
    logic [7:0] wv [0:3] = '{8'h02, 8'h40, 8'h80, 8'h00};
    logic [1:0] ev [0:3] = '{2'h0, 2'h1, 2'h2, 2'h0};
    pair_oe_ctrl = 2'h1;
    for (int k = 0; k < 4; k++) begin
      i_cbc_host.wr(`CBC_IDX_STOPFB, wv[k]);
      // halted level is registered one cycle behind the field
      @(negedge clk);
      chk(feedback_output_impedance, ev[k]);
      chk(clock_pair_output_run, 2'h1);
      chk(clock_pair_output_true[1], wv[k][1]);
      chk(clock_pair_output_comp, 2'h0);
    end
    i_cbc_host.wr(`CBC_IDX_PAIR0, 8'hBF);
    chk(pair0_impedance, 2'h2);
    i_cbc_host.rd(`CBC_IDX_PAIR0, 1);
    chk(i_cbc_host.got[1], 8'h80);
    // control bit clear halts pair 0 though its pin enables it; pin low halts pair 1
    pair_oe_ctrl = 2'h2;
    pair_enable_pin = 2'h1;
    repeat (6) @(negedge clk);
    chk(clock_pair_output_run, 2'h0);
  endtask
  task automatic t_sleep;
    sleep_pin = 1'b1;
    repeat (8) @(negedge clk);
    sleep_pin = 1'b0;
    repeat (5) @(negedge clk);
    chk(readback_length, 5'h03);
    i_cbc_host.wr(`CBC_IDX_SLEEP, 8'h00);
    chk(keep_config_in_sleep, 1'b0);
    sleep_pin = 1'b1;
    repeat (8) @(negedge clk);
    sleep_pin = 1'b0;
    chk(readback_length, 5'h08);
    chk(keep_config_in_sleep, 1'b1);
    chk({feedback_output_impedance, pair0_impedance}, 4'h5);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    // pin-derived outputs settle seven edges after release
    repeat (8) @(negedge clk);
    t_reset();
    t_rate();
    t_ident();
    t_len();
    t_stop();
    t_sleep();
    report_and_stop();
  end
endmodule
